// *** svw_pkg.sv ***
// Shared constants and types of the supervisor watchdog and reset block
package svw_pkg;

   // Master clock and internal timebase
   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned OSC_HZ       = 10_240;
   localparam int unsigned OSC_DIV_DEF  = CLK_HZ / OSC_HZ;

   // Printed times of the internal timebase
   localparam int unsigned RST_MS       = 50;
   localparam int unsigned WD_FAST_MS   = 100;
   localparam int unsigned WD_SLOW_MS   = 1600;

   // Same times as timebase ticks
   localparam int unsigned RST_TICKS     = RST_MS * OSC_HZ / 1000;
   localparam int unsigned WD_FAST_TICKS = WD_FAST_MS * OSC_HZ / 1000;
   localparam int unsigned WD_SLOW_TICKS = WD_SLOW_MS * OSC_HZ / 1000;

   // Counts when an external clock drives the timebase
   localparam int unsigned EXT_WD_NORM_CLKS = 1024;
   localparam int unsigned EXT_WD_LONG_CLKS = 4096;
   localparam int unsigned EXT_RST_CLKS     = 512;

   // Counter widths
   localparam int unsigned DIV_W  = 14;
   localparam int unsigned RCNT_W = 10;
   localparam int unsigned WCNT_W = 15;

   // Last count value of each period
   localparam logic [RCNT_W-1:0] RST_LAST     = RCNT_W'(RST_TICKS - 1);
   localparam logic [RCNT_W-1:0] EXT_RST_LAST = RCNT_W'(EXT_RST_CLKS - 1);
   localparam logic [WCNT_W-1:0] WD_FAST_LAST = WCNT_W'(WD_FAST_TICKS - 1);
   localparam logic [WCNT_W-1:0] WD_SLOW_LAST = WCNT_W'(WD_SLOW_TICKS - 1);
   localparam logic [WCNT_W-1:0] EXT_NORM_LAST = WCNT_W'(EXT_WD_NORM_CLKS - 1);
   localparam logic [WCNT_W-1:0] EXT_LONG_LAST = WCNT_W'(EXT_WD_LONG_CLKS - 1);

   // Pin synchroniser layout
   localparam int unsigned SYNC_W  = 8;
   localparam int unsigned IX_LL   = 0;
   localparam int unsigned IX_BB   = 1;
   localparam int unsigned IX_PF   = 2;
   localparam int unsigned IX_CE   = 3;
   localparam int unsigned IX_TOG  = 4;
   localparam int unsigned IX_VAL  = 5;
   localparam int unsigned IX_SEL  = 6;
   localparam int unsigned IX_TCK  = 7;

   // Reset sequencer states
   typedef enum logic [1:0] {
      SVW_HOLD = 2'b01,
      SVW_RUN  = 2'b10
   } svw_state_t;

endpackage

// *** svw_sync2.sv ***
// Two-flop synchroniser bank for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module svw_sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } svw_sync_t;

   svw_sync_t q_r;
   svw_sync_t q_nxt;

   // First stage feeds only the second
   always_comb begin
      q_nxt    = q_r;
      q_nxt.s1 = async_in;
      q_nxt.s2 = q_r.s1;
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign sync_out = q_r.s2;

endmodule // svw_sync2
`default_nettype wire

// *** svw_supervisor.sv ***
// Supervisor reset sequencer, watchdog and status flags
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Reset low while supply sense is under threshold or supply below backup.
// - Reset held a further 50 ms (512 external timing clocks when select is low) after the low condition clears.
// - Watchdog timeout produces a 50 ms reset pulse (512 external timing clocks when select is low).
// - Toggle input is three-level; host toggles it; a stuck level times out.
// - Every toggle transition restarts the watchdog count.
// - Floating or mid-supply toggle input disables the watchdog.
// - Power-fail flag low while power-fail sense is under threshold.
// - Supply below backup forces power-fail flag low.
// - Chip enable passes through, forced high while supply sense is low.
// - Backup flag high while output is fed from backup supply.
// - Supply-low flag follows supply sense with no delay on recovery.
// - Active-high reset is always the inverse of active-low reset.
// - Select high uses internal timebase; low uses the external timing clock.
// - Internal mode: timing pin low picks the fast watchdog period.
// - Expiry output low on timeout, high again on next toggle.
// - Expiry output held high while toggle input is undriven.
// - Expiry output forced high when the supply-low flag goes low.
// - Long period (1.6 s, or 4096 external timing clocks when select is low) applies right after any reset.
// - Normal period applies only after the first toggle following reset.
module svw_supervisor #(
   parameter int unsigned OSC_DIV = svw_pkg::OSC_DIV_DEF
) (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic supply_sense_in,
   input  wire logic supply_below_backup,
   input  wire logic power_fail_sense,
   input  wire logic chip_enable_in_n,
   input  wire logic watchdog_toggle_in,
   input  wire logic watchdog_drive_valid,
   input  wire logic timing_source_select,
   input  wire logic timing_clock_in,
   output logic      reset_out_n,
   output logic      reset_out,
   output logic      watchdog_expired_n,
   output logic      power_fail_flag_n,
   output logic      supply_low_flag_n,
   output logic      chip_enable_out_n,
   output logic      on_backup_flag
);

   typedef struct packed {
      svw_pkg::svw_state_t             st;
      logic [svw_pkg::DIV_W-1:0]       div;
      logic [svw_pkg::RCNT_W-1:0]      rcnt;
      logic [svw_pkg::WCNT_W-1:0]      wcnt;
      logic                            long_mode;
      logic                            tog_prev;
      logic                            tck_prev;
      logic                            reset_n;
      logic                            reset_hi;
      logic                            expired_n;
      logic                            pf_n;
      logic                            sl_n;
      logic                            ce_n;
      logic                            backup;
      logic [1:0]                      settle;
   } svw_core_t;

   svw_core_t                  q_r;
   svw_core_t                  q_nxt;
   logic [svw_pkg::SYNC_W-1:0] pins_s;
   logic                       tick;
   logic                       tog_edge;
   logic                       wd_fire;
   logic                       low_cond;
   logic [svw_pkg::WCNT_W-1:0] wd_last;
   logic [svw_pkg::RCNT_W-1:0] rst_last;

   // Last watchdog count for the current timebase and mode
   function automatic logic [svw_pkg::WCNT_W-1:0] wd_limit(
      input logic long_m,
      input logic int_sel,
      input logic slow_pin
   );
      logic [svw_pkg::WCNT_W-1:0] lim;
      lim = svw_pkg::WD_SLOW_LAST;
      if (!int_sel) begin
         lim = long_m ? svw_pkg::EXT_LONG_LAST : svw_pkg::EXT_NORM_LAST;
      end else if (!long_m && !slow_pin) begin
         lim = svw_pkg::WD_FAST_LAST;
      end
      return lim;
   endfunction

   // All pins cross into the clock domain
   svw_sync2 #(
      .W (svw_pkg::SYNC_W)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .async_in ({timing_clock_in, timing_source_select, watchdog_drive_valid,
                  watchdog_toggle_in, chip_enable_in_n, power_fail_sense,
                  supply_below_backup, supply_sense_in}),
      .sync_out (pins_s)
   );

   // Watchdog period and reset width selection
   always_comb begin
      wd_last  = wd_limit(q_r.long_mode, pins_s[svw_pkg::IX_SEL], pins_s[svw_pkg::IX_TCK]);
      rst_last = pins_s[svw_pkg::IX_SEL] ? svw_pkg::RST_LAST : svw_pkg::EXT_RST_LAST;
   end

   // Main next-state logic
   always_comb begin
      q_nxt          = q_r;
      q_nxt.tog_prev = pins_s[svw_pkg::IX_TOG];
      q_nxt.tck_prev = pins_s[svw_pkg::IX_TCK];
      low_cond       = pins_s[svw_pkg::IX_LL] | pins_s[svw_pkg::IX_BB];

      tick = 1'b0;
      if (pins_s[svw_pkg::IX_SEL]) begin
         if (q_r.div == svw_pkg::DIV_W'(OSC_DIV - 1)) begin
            tick      = 1'b1;
            q_nxt.div = '0;
         end else begin
            q_nxt.div = q_r.div + 1'b1;
         end
      end else begin
         tick      = pins_s[svw_pkg::IX_TCK] & ~q_r.tck_prev;
         q_nxt.div = '0;
      end

      tog_edge = pins_s[svw_pkg::IX_VAL] & (pins_s[svw_pkg::IX_TOG] ^ q_r.tog_prev);
      wd_fire  = (q_r.st == svw_pkg::SVW_RUN) && pins_s[svw_pkg::IX_VAL] && !tog_edge
                 && tick && (q_r.wcnt == wd_last) && !low_cond;

      case (q_r.st)
         svw_pkg::SVW_HOLD: begin
            q_nxt.reset_n   = 1'b0;
            q_nxt.wcnt      = '0;
            q_nxt.long_mode = 1'b1;
            if (low_cond) begin
               q_nxt.rcnt = '0;
            end else if (tick) begin
               if (q_r.rcnt == rst_last) begin
                  q_nxt.st      = svw_pkg::SVW_RUN;
                  q_nxt.reset_n = 1'b1;
                  q_nxt.rcnt    = '0;
               end else begin
                  q_nxt.rcnt = q_r.rcnt + 1'b1;
               end
            end
         end
         svw_pkg::SVW_RUN: begin
            if (low_cond) begin
               q_nxt.st      = svw_pkg::SVW_HOLD;
               q_nxt.reset_n = 1'b0;
               q_nxt.rcnt    = '0;
               q_nxt.wcnt    = '0;
            end else if (wd_fire) begin
               q_nxt.st        = svw_pkg::SVW_HOLD;
               q_nxt.reset_n   = 1'b0;
               q_nxt.rcnt      = '0;
               q_nxt.wcnt      = '0;
               q_nxt.expired_n = 1'b0;
            end else if (!pins_s[svw_pkg::IX_VAL]) begin
               q_nxt.wcnt = '0;
            end else if (tog_edge) begin
               q_nxt.wcnt      = '0;
               q_nxt.long_mode = 1'b0;
            end else if (tick) begin
               q_nxt.wcnt = q_r.wcnt + 1'b1;
            end
         end
         default: begin
            q_nxt.st      = svw_pkg::SVW_HOLD;
            q_nxt.reset_n = 1'b0;
            q_nxt.rcnt    = '0;
         end
      endcase

      if (tog_edge || !pins_s[svw_pkg::IX_VAL] || pins_s[svw_pkg::IX_LL]) begin
         q_nxt.expired_n = 1'b1;
      end

      q_nxt.reset_hi = ~q_nxt.reset_n;
      q_nxt.pf_n     = ~(pins_s[svw_pkg::IX_PF] | pins_s[svw_pkg::IX_BB]);
      q_nxt.sl_n     = ~pins_s[svw_pkg::IX_LL];
      // chip enable gating, held high until the synchronisers fill
      q_nxt.settle   = {q_r.settle[0], 1'b1};
      q_nxt.ce_n     = pins_s[svw_pkg::IX_LL] | pins_s[svw_pkg::IX_CE] | ~q_r.settle[1];
      q_nxt.backup   = pins_s[svw_pkg::IX_BB];
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q_r           <= '0;
         q_r.st        <= svw_pkg::SVW_HOLD;
         q_r.long_mode <= 1'b1;
         q_r.reset_hi  <= 1'b1;
         q_r.expired_n <= 1'b1;
         q_r.pf_n      <= 1'b1;
         q_r.sl_n      <= 1'b1;
         q_r.ce_n      <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   // Outputs straight from the state register
   assign reset_out_n        = q_r.reset_n;
   assign reset_out          = q_r.reset_hi;
   assign watchdog_expired_n = q_r.expired_n;
   assign power_fail_flag_n  = q_r.pf_n;
   assign supply_low_flag_n  = q_r.sl_n;
   assign chip_enable_out_n  = q_r.ce_n;
   assign on_backup_flag     = q_r.backup;

   // Checks on the sequencer and flags
   sequence s_low_clear;
      $fell(pins_s[svw_pkg::IX_LL]) && !pins_s[svw_pkg::IX_BB];
   endsequence

   sequence s_held_low;
      !reset_out_n [*8];
   endsequence

   property p_low_reset;
      @(posedge sys_clk) disable iff (!rst_b)
      low_cond |=> !reset_out_n;
   endproperty
   a_low_reset: assert property (p_low_reset) else $error("reset not low on low supply");

   property p_hold_after;
      @(posedge sys_clk) disable iff (!rst_b)
      s_low_clear |=> s_held_low;
   endproperty
   a_hold_after: assert property (p_hold_after) else $error("reset released too early");

   property p_wd_pulse;
      @(posedge sys_clk) disable iff (!rst_b)
      wd_fire |=> (!reset_out_n && !watchdog_expired_n);
   endproperty
   a_wd_pulse: assert property (p_wd_pulse) else $error("timeout gave no reset");

   property p_restart;
      @(posedge sys_clk) disable iff (!rst_b)
      (tog_edge && q_r.st == svw_pkg::SVW_RUN && !low_cond) |=> (q_r.wcnt == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("toggle did not restart count");

   property p_undriven;
      @(posedge sys_clk) disable iff (!rst_b)
      !pins_s[svw_pkg::IX_VAL] |=> (watchdog_expired_n && q_r.wcnt == '0);
   endproperty
   a_undriven: assert property (p_undriven) else $error("watchdog active while undriven");

   property p_pfail;
      @(posedge sys_clk) disable iff (!rst_b)
      ##1 power_fail_flag_n == !$past(pins_s[svw_pkg::IX_PF] | pins_s[svw_pkg::IX_BB]);
   endproperty
   a_pfail: assert property (p_pfail) else $error("power-fail flag wrong");

   property p_ce_gate;
      @(posedge sys_clk) disable iff (!rst_b)
      pins_s[svw_pkg::IX_LL] |=> chip_enable_out_n;
   endproperty
   a_ce_gate: assert property (p_ce_gate) else $error("chip enable not blocked");

   property p_inverse;
      @(posedge sys_clk) disable iff (!rst_b)
      reset_out != reset_out_n;
   endproperty
   a_inverse: assert property (p_inverse) else $error("reset outputs not complementary");

   property p_expiry_low_line;
      @(posedge sys_clk) disable iff (!rst_b)
      $fell(supply_low_flag_n) |-> watchdog_expired_n;
   endproperty
   a_expiry_low_line: assert property (p_expiry_low_line) else $error("expiry low on low line");

   property p_long_after;
      @(posedge sys_clk) disable iff (!rst_b)
      $rose(reset_out_n) |-> q_r.long_mode;
   endproperty
   a_long_after: assert property (p_long_after) else $error("short period after reset");

endmodule // svw_supervisor
`default_nettype wire

// *** svw_host_model.sv ***
// Host processor model that services the watchdog toggle pin
`timescale 1ns/100ps
`default_nettype none
module svw_host_model (
   input  wire logic        sys_clk,
   input  wire logic        reset_out_n,
   input  wire logic        drive_en,
   input  wire logic [15:0] gap,
   output logic             watchdog_toggle_in,
   output logic             watchdog_drive_valid
);
   logic [15:0] cnt;

   // Toggle pin driver, changed just after each edge
   initial begin
      watchdog_toggle_in = 1'b0;
      watchdog_drive_valid = 1'b1;
      cnt = 16'h0000;
      forever begin
         @(posedge sys_clk);
         #1;
         if (!drive_en) begin
            watchdog_drive_valid = 1'b0;
            watchdog_toggle_in = ~watchdog_toggle_in;
            cnt = 16'h0000;
         end else begin
            watchdog_drive_valid = 1'b1;
            if (gap == 16'h0000 || !reset_out_n) begin
               cnt = 16'h0000;
            end else if (cnt == gap - 16'h0001) begin
               cnt = 16'h0000;
               watchdog_toggle_in = ~watchdog_toggle_in;
            end else begin
               cnt = cnt + 16'h0001;
            end
         end
      end
   end
endmodule // svw_host_model
`default_nettype wire

// *** tb_supervisor_watchdog_reset.sv ***
// Self-checking testbench of the supervisor watchdog and reset block
`timescale 1ns/100ps
`default_nettype none
module tb_supervisor_watchdog_reset;
   logic        sys_clk;
   logic        rst_b;
   logic        supply_sense_in;
   logic        supply_below_backup;
   logic        power_fail_sense;
   logic        chip_enable_in_n;
   logic        timing_source_select;
   logic        timing_clock_in;
   logic        watchdog_toggle_in;
   logic        watchdog_drive_valid;
   logic        reset_out_n;
   logic        reset_out;
   logic        watchdog_expired_n;
   logic        power_fail_flag_n;
   logic        supply_low_flag_n;
   logic        chip_enable_out_n;
   logic        on_backup_flag;
   logic        drive_en;
   logic        ext_run;
   logic [1:0]  ph;
   logic [15:0] gap;
   logic [6:0]  outs;
   logic [1:0]  mon;
   int          failures;
   int          checked;

   // Observed outputs in one vector
   assign outs = {reset_out_n, reset_out, watchdog_expired_n, power_fail_flag_n,
                  supply_low_flag_n, chip_enable_out_n, on_backup_flag};
   assign mon = {watchdog_expired_n, reset_out_n};

   svw_supervisor #(.OSC_DIV(4)) dut (
      .sys_clk              (sys_clk),
      .rst_b                (rst_b),
      .supply_sense_in      (supply_sense_in),
      .supply_below_backup  (supply_below_backup),
      .power_fail_sense     (power_fail_sense),
      .chip_enable_in_n     (chip_enable_in_n),
      .watchdog_toggle_in   (watchdog_toggle_in),
      .watchdog_drive_valid (watchdog_drive_valid),
      .timing_source_select (timing_source_select),
      .timing_clock_in      (timing_clock_in),
      .reset_out_n          (reset_out_n),
      .reset_out            (reset_out),
      .watchdog_expired_n   (watchdog_expired_n),
      .power_fail_flag_n    (power_fail_flag_n),
      .supply_low_flag_n    (supply_low_flag_n),
      .chip_enable_out_n    (chip_enable_out_n),
      .on_backup_flag       (on_backup_flag)
   );

   svw_host_model u_host (
      .sys_clk              (sys_clk),
      .reset_out_n          (reset_out_n),
      .drive_en             (drive_en),
      .gap                  (gap),
      .watchdog_toggle_in   (watchdog_toggle_in),
      .watchdog_drive_valid (watchdog_drive_valid)
   );

   // 125 MHz clock
   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   // External timing clock, one tick per four cycles
   initial begin
      ph = 2'b00;
      timing_clock_in = 1'b0;
      forever begin
         @(posedge sys_clk);
         #1;
         if (ext_run) begin
            ph = ph + 2'b01;
            timing_clock_in = ph[1];
         end
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic complete_run();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [6:0] seen, input logic [6:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bounded wait for one output level
   task automatic wait_on(input int idx, input logic val, input int bound);
      int n;
      n = 0;
      while (mon[idx] !== val && n < bound) begin
         cyc(1);
         n++;
      end
      check({6'h00, mon[idx]}, {6'h00, val});
      if (mon[idx] !== val) complete_run();
   endtask

   // Main sequence
   initial begin
      rst_b = 1'b0;
      supply_sense_in = 1'b1;
      supply_below_backup = 1'b0;
      power_fail_sense = 1'b0;
      chip_enable_in_n = 1'b0;
      timing_source_select = 1'b1;
      ext_run = 1'b0;
      drive_en = 1'b1;
      gap = 16'h0000;
      failures = 0;
      checked = 0;
      cyc(6);
      check(outs, 7'h3e);
      rst_b = 1'b1;
      cyc(4);
      check(outs, 7'h3a);
      supply_sense_in = 1'b0;
      cyc(3);
      check(outs, 7'h3c);
      cyc(2000);
      check(outs, 7'h3c);
      wait_on(0, 1'b1, 100);
      check(outs, 7'h5c);
      $display("test power_on done");
      // One toggle, then the fast internal period must expire
      gap = 16'd100;
      cyc(130);
      gap = 16'h0000;
      cyc(3500);
      check(outs, 7'h5c);
      wait_on(1, 1'b0, 800);
      check(outs, 7'h2c);
      wait_on(0, 1'b1, 2200);
      check(outs, 7'h4c);
      gap = 16'd100;
      wait_on(1, 1'b1, 120);
      gap = 16'h0000;
      $display("test fast watchdog done");
      power_fail_sense = 1'b1;
      chip_enable_in_n = 1'b1;
      cyc(3);
      check(outs, 7'h56);
      power_fail_sense = 1'b0;
      chip_enable_in_n = 1'b0;
      cyc(3);
      check(outs, 7'h5c);
      supply_below_backup = 1'b1;
      timing_source_select = 1'b0;
      ext_run = 1'b1;
      cyc(3);
      check(outs, 7'h35);
      supply_below_backup = 1'b0;
      cyc(3);
      check(outs, 7'h3c);
      cyc(2000);
      check(outs, 7'h3c);
      wait_on(0, 1'b1, 100);
      $display("test flags done");
      cyc(16000);
      check(outs, 7'h5c);
      wait_on(1, 1'b0, 600);
      check(outs, 7'h2c);
      cyc(2000);
      check(outs, 7'h2c);
      wait_on(0, 1'b1, 100);
      check(outs, 7'h4c);
      gap = 16'd3000;
      cyc(3000);
      wait_on(1, 1'b1, 10);
      cyc(9000);
      check(outs, 7'h5c);
      gap = 16'h0000;
      cyc(1000);
      check(outs, 7'h5c);
      wait_on(1, 1'b0, 4200);
      $display("test watchdog done");
      supply_sense_in = 1'b1;
      cyc(3);
      check(outs, 7'h3a);
      supply_sense_in = 1'b0;
      wait_on(0, 1'b1, 2200);
      check(outs, 7'h5c);
      drive_en = 1'b0;
      cyc(18000);
      check(outs, 7'h5c);
      $display("test float done");
      complete_run();
   end
endmodule // tb_supervisor_watchdog_reset
`default_nettype wire
